// ### design/stts_top.sv
`default_nettype none
module stts_top
  import stts_pkg::*;
#(
  parameter int unsigned NUM_TRIG = 2,
  parameter int unsigned TS_W     = 64
) (
  // Clock and reset.
  input  wire logic                clk_i,
  input  wire logic                rst_n_i,
  // Register port.
  input  wire logic [3:0]          addr_i,
  input  wire logic [31:0]         wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [31:0]         rdata_o,
  // Trigger port pins.
  input  wire logic                sync_i,
  output logic      [NUM_TRIG-1:0] trig_o,
  // Frame set event from the capture path.
  input  wire logic                frame_i
);

  logic [31:0]         ctrl_q;
  logic [31:0]         period_q;
  logic [31:0]         width_q;
  logic [31:0]         phase_q;
  logic [NUM_TRIG-1:0] trig_q;
  logic [7:0]          div_q;
  logic [TS_W-1:0]     ts_q;
  logic [TS_W-1:0]     stamp_q;
  logic [31:0]         seq_q;
  logic [2:0]          sync_sr_q;
  logic                sync_lvl_q;
  logic                sync_edge;
  logic                us_tick;
  logic [NUM_TRIG-1:0] line_used_q;
  logic [1:0]          cam_line_q;
  logic                cam_ext_q;
  logic                pps_seen_q;
  logic [31:0]         rdata_q;
  logic                pulse_on;

  localparam logic [7:0] DIV_LAST = 8'(TICKS_PER_US - 1);

  // Software configuration writes.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_q   <= CTRL_RST;
      period_q <= PERIOD_RST;
      width_q  <= WIDTH_RST;
    end else if (wr_i) begin
      case (addr_i)
        REG_CTRL:   ctrl_q   <= wdata_i;
        REG_PERIOD: period_q <= wdata_i;
        REG_WIDTH:  width_q  <= wdata_i;
        default: ;
      endcase
    end
  end

  // Sync pin passes three flops; a change counts once stages two and three
  // agree, which also filters a single-cycle glitch.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync_sr_q  <= 3'h0;
      sync_lvl_q <= 1'b0;
    end else begin
      sync_sr_q <= {sync_sr_q[1:0], sync_i};
      if (sync_sr_q[1] == sync_sr_q[2]) begin
        sync_lvl_q <= sync_sr_q[2];
      end
    end
  end

  assign sync_edge = (sync_sr_q[1] & sync_sr_q[2]) & ~sync_lvl_q
                     & ctrl_q[CTRL_PPS_EN];

  // Microsecond prescaler; restarted by a sync edge so the tick grid aligns.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      div_q <= 8'h00;
    end else if (sync_edge || div_q == DIV_LAST) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  assign us_tick = (div_q == DIV_LAST);

  // Timestamp clock: zero from reset, free running, cleared by sync edge.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ts_q <= '0;
    end else if (sync_edge) begin
      ts_q <= '0;
    end else if (us_tick) begin
      ts_q <= ts_q + TS_W'(1);
    end
  end

  // Frame set stamp and sequence number.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stamp_q <= '0;
      seq_q   <= ZERO32;
    end else if (frame_i) begin
      stamp_q <= ts_q;
      seq_q   <= seq_q + 32'h1;
    end
  end

  // Trigger phase counter; a zero period is treated as one cycle.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= ZERO32;
    end else if (phase_q + 32'h1 >= period_q) begin
      phase_q <= ZERO32;
    end else begin
      phase_q <= phase_q + 32'h1;
    end
  end

  assign pulse_on = (phase_q < width_q);

  // Each line has its own enable and its own output flop.
  for (genvar g = 0; g < NUM_TRIG; g++) begin : g_trig
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        trig_q[g] <= 1'b0;
      end else begin
        trig_q[g] <= pulse_on & ctrl_q[CTRL_TRIG_EN0 + g];
      end
    end
  end

  // New camera: external trigger on, first line not yet assigned.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      line_used_q <= '0;
      cam_line_q  <= 2'h0;
      cam_ext_q   <= 1'b0;
    end else if (wr_i && addr_i == REG_CAM_NEW) begin
      cam_ext_q <= 1'b1;
      if (!line_used_q[0]) begin
        line_used_q[0] <= 1'b1;
        cam_line_q     <= 2'h0;
      end else if (!line_used_q[1]) begin
        line_used_q[1] <= 1'b1;
        cam_line_q     <= 2'h1;
      end
    end
  end

  // Sticky sync-seen flag; a new edge wins over the clear on read.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pps_seen_q <= 1'b0;
    end else if (sync_edge) begin
      pps_seen_q <= 1'b1;
    end else if (rd_i && addr_i == REG_STATUS) begin
      pps_seen_q <= 1'b0;
    end
  end

  // Read data, valid the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_q <= ZERO32;
    end else if (rd_i) begin
      case (addr_i)
        REG_CTRL:     rdata_q <= ctrl_q;
        REG_PERIOD:   rdata_q <= period_q;
        REG_WIDTH:    rdata_q <= width_q;
        REG_TS_LO:    rdata_q <= stamp_q[31:0];
        REG_TS_HI:    rdata_q <= stamp_q[TS_W-1:32];
        REG_SEQ:      rdata_q <= seq_q;
        REG_STATUS:   rdata_q <= {29'h0, pps_seen_q, trig_q};
        REG_CAM_LINE: rdata_q <= {29'h0, cam_ext_q, cam_line_q};
        default:      rdata_q <= ZERO32;
      endcase
    end else begin
      rdata_q <= ZERO32;
    end
  end

  assign rdata_o = rdata_q;
  assign trig_o  = trig_q;

  // Checks.
  sync_clears_ts_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sync_edge |=> ts_q == '0)
    else $error("timestamp not cleared by sync edge");
  // Checked on the timestamp itself, so it also catches a clear that slips
  // in by some other path while sync is disabled.
  sync_off_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!ctrl_q[CTRL_PPS_EN] && ts_q != '0) |=> ts_q != '0)
    else $error("timestamp cleared while sync disabled");
  one_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sync_edge |=> !sync_edge)
    else $error("sync edge lasted two cycles");
  ts_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (us_tick && !sync_edge) |=> ts_q == $past(ts_q) + TS_W'(1))
    else $error("timestamp did not advance on tick");
  ts_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (!us_tick && !sync_edge) |=> $stable(ts_q))
    else $error("timestamp moved between ticks");
  trig_width_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (pulse_on && ctrl_q[CTRL_TRIG_EN0]) |=> trig_o[0])
    else $error("trigger low during pulse");
  trig_idle_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !pulse_on |=> trig_o == '0)
    else $error("trigger high outside pulse");
  seq_step_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    frame_i |=> seq_q == $past(seq_q) + 32'h1 && stamp_q == $past(ts_q))
    else $error("frame set stamp or sequence wrong");
  cam_first_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (wr_i && addr_i == REG_CAM_NEW && !line_used_q[0])
      |=> cam_line_q == 2'h0 && cam_ext_q)
    else $error("new camera not given first line");

  pps_seen_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    sync_edge);
  trig_rise_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(trig_o[1]));
  frame_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    frame_i ##1 frame_i);

endmodule
`default_nettype wire

// ### shared/stts_pkg.sv
`default_nettype none
package stts_pkg;
  // Clock rate and the microsecond tick derived from it.
  localparam int unsigned CLK_HZ       = 100000000;
  localparam int unsigned US_PER_S     = 1000000;
  localparam int unsigned TICKS_PER_US = CLK_HZ / US_PER_S;

  // Register word indices on the plain register port.
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_PERIOD   = 4'h1;
  localparam logic [3:0] REG_WIDTH    = 4'h2;
  localparam logic [3:0] REG_TS_LO    = 4'h3;
  localparam logic [3:0] REG_TS_HI    = 4'h4;
  localparam logic [3:0] REG_SEQ      = 4'h5;
  localparam logic [3:0] REG_STATUS   = 4'h6;
  localparam logic [3:0] REG_CAM_NEW  = 4'h7;
  localparam logic [3:0] REG_CAM_LINE = 4'h8;

  // Control register fields.
  localparam int unsigned CTRL_TRIG_EN0 = 0;
  localparam int unsigned CTRL_TRIG_EN1 = 1;
  localparam int unsigned CTRL_PPS_EN   = 2;

  // Reset values of the configuration registers.
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] PERIOD_RST = 32'h0001_86A0;
  localparam logic [31:0] WIDTH_RST  = 32'h0000_03E8;
  localparam logic [31:0] ZERO32     = 32'h0000_0000;
endpackage
`default_nettype wire

// ### dv/stts_pps_model.sv
`default_nettype none
module stts_pps_model (
  // Clock and the bench's request for one sync edge.
  input  wire logic       clk_i,
  input  wire logic       fire_i,
  input  wire logic [1:0] trig_i,
  // Sync pin and count of exposures started.
  output logic            sync_o,
  output logic [15:0]     shots_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hold_q = 4'h0;
  logic       trig_q = 1'b0;
  logic [15:0] shots_q = 16'h0;

  assign shots_o = shots_q;
  // One rising edge a request, held for eight cycles.
  always @(posedge clk_i) begin
    if (fire_i) hold_q <= 4'h8;
    else if (hold_q != 4'h0) hold_q <= hold_q - 4'h1;
  end
  assign sync_o = (hold_q != 4'h0);
  // Cameras start only on a rising edge, so a stuck high adds nothing.
  always @(posedge clk_i) begin
    trig_q <= trig_i[0];
    if (trig_i[0] && !trig_q) shots_q <= shots_q + 16'h1;
  end
endmodule
`default_nettype wire

// ### dv/test_stereo_trigger_time_sync.sv
`default_nettype none
module test_stereo_trigger_time_sync
  import stts_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        frame_i = 1'b0;
  logic        fire = 1'b0;
  logic        sync_i;
  logic [3:0]  addr_i = 4'h0;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] rdata_o;
  logic [31:0] got;
  logic [1:0]  trig_o;
  logic [15:0] shots;
  int          n_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;

  stts_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .sync_i(sync_i), .trig_o(trig_o), .frame_i(frame_i));
  stts_pps_model u_pps (.clk_i(clk_i), .fire_i(fire), .trig_i(trig_o),
    .sync_o(sync_i), .shots_o(shots));

  // Clock and a cycle ceiling well above the test length.
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      results();
    end
  end

  task automatic results();
    if (n_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, e, input string m);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask

  // Register port cycles; read data is taken in the cycle after the strobe.
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic stamp(output logic [31:0] ts);
    @(posedge clk_i);
    frame_i <= 1'b1;
    @(posedge clk_i);
    frame_i <= 1'b0;
    rd(REG_TS_LO, ts);
  endtask
  task automatic sync_gap();
    @(posedge clk_i);
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (294) @(posedge clk_i);
  endtask

  task automatic t_reset_vals();
    stamp(got);
    chk(got, ZERO32, "start stamp");
    chk({30'h0, trig_o}, ZERO32, "idle");
    rd(REG_CTRL, got);
    chk(got, CTRL_RST, "ctrl");
    rd(REG_PERIOD, got);
    chk(got, PERIOD_RST, "period");
    rd(REG_WIDTH, got);
    chk(got, WIDTH_RST, "width");
    rd(4'hF, got);
    chk(got, ZERO32, "unmapped");
  endtask

  // Any 100-cycle window of a 20/5 pattern holds 25 high cycles.
  task automatic t_trigger();
    logic [31:0] h0, h1, s0;
    wr(REG_PERIOD, 32'h14);
    wr(REG_WIDTH, 32'h5);
    wr(REG_CTRL, 32'h3);
    repeat (40) @(posedge clk_i);
    // Taken off the edge so the window holds exactly 100 model edges.
    #1 s0 = shots;
    h0 = 0;
    h1 = 0;
    repeat (100) begin
      @(posedge clk_i);
      #1 h0 += trig_o[0];
      h1 += trig_o[1];
    end
    chk(h0, 25, "high0");
    chk(h1, 25, "high1");
    chk(shots - s0, 5, "edges");
    wr(REG_CTRL, 32'h2);
    h0 = 0;
    h1 = 0;
    repeat (60) begin
      @(posedge clk_i);
      #1 h0 += trig_o[0];
      h1 += trig_o[1];
    end
    chk(h0, 0, "off");
    chk(h1, 15, "still on");
  endtask

  // Frames 300 cycles apart are three microseconds apart.
  task automatic t_stamp_pps();
    logic [31:0] a, b, s1, s2;
    wr(REG_CTRL, ZERO32);
    rd(REG_SEQ, s1);
    stamp(a);
    sync_gap();
    stamp(b);
    rd(REG_SEQ, s2);
    chk(b - a, 32'h3, "us step");
    chk(s2 - s1, 32'h2, "seq");
    rd(REG_TS_HI, got);
    chk(got, ZERO32, "stamp high");
    chk(b - a, 32'h3, "sync off");
    wr(REG_CTRL, 32'h4);
    repeat (20) @(posedge clk_i);
    sync_gap();
    stamp(a);
    chk(a, 32'h2, "one clear");
    rd(REG_STATUS, b);
    chk(b & 32'h4, 32'h4, "seen");
    rd(REG_STATUS, b);
    chk(b & 32'h4, ZERO32, "seen cleared");
    fire <= 1'b1;
    @(posedge clk_i);
    fire <= 1'b0;
    repeat (30) @(posedge clk_i);
    stamp(a);
    chk(a, ZERO32, "cleared");
    // Two frame events back to back each count once.
    @(posedge clk_i);
    frame_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    frame_i <= 1'b0;
    rd(REG_SEQ, s1);
    chk(s1 - s2, 32'h4, "back to back");
  endtask

  task automatic t_camera();
    for (int i = 0; i < 3; i++) begin
      wr(REG_CAM_NEW, 32'h1);
      rd(REG_CAM_LINE, got);
      chk(got, (i == 0) ? 32'h4 : 32'h5, "line");
    end
  endtask

  // Reset, then the scenarios in turn.
  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset_vals();
    t_trigger();
    t_stamp_pps();
    t_camera();
    results();
  end
endmodule
`default_nettype wire
